//--- common/uabm_defines.svh
// constants for the auto baud matcher: offsets, fields, resets, ranges
`ifndef UABM_DEFINES_SVH
`define UABM_DEFINES_SVH
`define UABM_OFS_CAPTURE_CTRL 4'h0
`define UABM_OFS_WIDTH 4'h4
`define UABM_OFS_DIVISOR 4'h8
`define UABM_OFS_STATUS 4'hc
`define UABM_CTRL_EDGE_LSB 0
`define UABM_CTRL_EDGE_MSB 1
`define UABM_CTRL_SRC_BIT 2
`define UABM_CTRL_EN_BIT 3
`define UABM_RST_EDGE 2'h2
`define UABM_RST_SRC 1'h0
`define UABM_RST_EN 1'h1
`define UABM_RST_DIV 16'h0000
`define UABM_SRC_PIN 1'h0
`define UABM_EDGE_OFF 2'h0
`define UABM_EDGE_RISE 2'h1
`define UABM_EDGE_FALL 2'h2
`define UABM_EDGE_BOTH 2'h3
`define UABM_ONE_MIN 24'h000b86
`define UABM_ONE_MAX 24'h000e24
`define UABM_TWO_MIN 24'h00170c
`define UABM_TWO_MAX 24'h001c48
`define UABM_THREE_MIN 24'h002292
`define UABM_THREE_MAX 24'h002a6c
`define UABM_FOUR_MIN 24'h002e19
`define UABM_FOUR_MAX 24'h003891
`define UABM_THIRD_MUL 12'haaa
`define UABM_TWO_MASK 16'hffff
`define UABM_LOW_MASK 16'h00ff
`define UABM_MID_SHIFT 8
`endif

//--- common/uabm_pkg.sv
// types for the auto baud matcher
package uabm_pkg;
   typedef enum logic [1:0] {
      ST_FIRST = 2'b00,
      ST_SECOND = 2'b01,
      ST_APPLY = 2'b11,
      ST_RELEASE = 2'b10
   } uabm_fsm_type;
   typedef enum logic [2:0] {
      CL_NONE = 3'h0,
      CL_ONE = 3'h1,
      CL_TWO = 3'h2,
      CL_THREE = 3'h3,
      CL_FOUR = 3'h4,
      CL_REJECT = 3'h7
   } uabm_class_type;
   typedef struct packed {
      logic [7:0] midDiv;
      logic [7:0] lowDiv;
      logic softResetN;
   } uabm_port_cfg_type;
   typedef struct packed {
      logic enable;
      logic srcSel;
      logic [1:0] edgeSel;
   } uabm_ctrl_type;
   typedef struct packed {
      uabm_fsm_type fsm;
      uabm_ctrl_type ctrl;
      uabm_class_type lastClass;
      logic [23:0] count;
      logic [23:0] stamp;
      logic [23:0] width;
      logic [15:0] divisor;
      logic softResetN;
      logic inPrev;
      logic waitReq;
      logic [31:0] readData;
   } uabm_state_type;
endpackage : uabm_pkg

//--- hdl/uabm_matcher.sv
// auto baud matcher: pulse capture, classification, divisor load, bus slave
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "uabm_defines.svh"
// What this block does
// R1: width 5900..7240 counts is two-bit pulse
// R2: two-bit divisor is (width>>4 & ffff)-1
// R3: width 8850..10860 counts is three-bit pulse
// R4: three-bit divisor is (width*2730>>16)-1
// R5: width 11801..14481 counts is four-bit pulse
// R6: four-bit divisor is (width>>5)-1
// R7: never adjust from five-or-more-bit pulses
// R8: load mid and low fields of both ports
// R9: capture source select 0 takes capture pin
// R10: edge select 2 stamps falling edges
// R11: width is second stamp minus first, rearm
// R12: width 2950..3620 is one-bit, (width>>3)-1
// R13: pulse soft reset low then high after load
// R14: out-of-range width leaves fields and resets alone
// R15: peer sends low start bit plus data
module uabm_matcher
   import uabm_pkg::*;
#(
   parameter int COUNT_W = 24
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // capture inputs
   input wire logic captureInputPin,
   input wire logic rxLineInternal,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // divisor and soft reset of both serial ports
   output uabm_port_cfg_type portCfg [2]
);

   uabm_state_type s_q;
   uabm_state_type s_d;

   logic capIn;
   logic edgeSeen;
   logic inOne;
   logic inTwo;
   logic inThree;
   logic inFour;
   logic [35:0] thirdProd;
   logic [15:0] divNext;
   logic busTake;

   // the pin is the only external source; anything else is the internal rx tap
   assign capIn = (s_q.ctrl.srcSel == `UABM_SRC_PIN) ? captureInputPin : rxLineInternal; // [R9]

   always_comb begin
      edgeSeen = 1'b0;
      case (s_q.ctrl.edgeSel)
         `UABM_EDGE_RISE: edgeSeen = !s_q.inPrev && capIn;
         `UABM_EDGE_FALL: edgeSeen = s_q.inPrev && !capIn; // [R10]
         `UABM_EDGE_BOTH: edgeSeen = s_q.inPrev != capIn;
         default: edgeSeen = 1'b0;
      endcase
   end

   assign inOne = s_q.width >= `UABM_ONE_MIN && s_q.width <= `UABM_ONE_MAX; // [R12]
   assign inTwo = s_q.width >= `UABM_TWO_MIN && s_q.width <= `UABM_TWO_MAX; // [R1]
   assign inThree = s_q.width >= `UABM_THREE_MIN && s_q.width <= `UABM_THREE_MAX; // [R3]
   assign inFour = s_q.width >= `UABM_FOUR_MIN && s_q.width <= `UABM_FOUR_MAX; // [R5]
   // multiply-and-shift stands in for a divide by 24; it truncates slightly low
   assign thirdProd = {12'h000, s_q.width} * {24'h000000, `UABM_THIRD_MUL}; // [R4]
   assign busTake = (avs_read || avs_write) && s_q.waitReq;

   always_comb begin
      divNext = s_q.divisor;
      if (inOne) begin
         divNext = {3'h0, s_q.width[15:3]} - 16'h0001; // [R12]
      end else if (inTwo) begin
         divNext = (s_q.width[19:4] & `UABM_TWO_MASK) - 16'h0001; // [R2]
      end else if (inThree) begin
         divNext = thirdProd[31:16] - 16'h0001; // [R4]
      end else if (inFour) begin
         divNext = s_q.width[20:5] - 16'h0001; // [R6]
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.count = s_q.count + 24'h000001;
      s_d.inPrev = capIn;
      case (s_q.fsm)
         ST_FIRST: begin
            if (s_q.ctrl.enable && edgeSeen) begin
               s_d.stamp = s_q.count;
               s_d.fsm = ST_SECOND;
            end
         end
         ST_SECOND: begin
            if (!s_q.ctrl.enable) begin
               s_d.fsm = ST_FIRST;
            end else if (edgeSeen) begin
               s_d.width = s_q.count - s_q.stamp; // [R11]
               s_d.fsm = ST_APPLY;
            end
         end
         ST_APPLY: begin
            // five-bit and longer pulses overlap their neighbours, so nothing loads
            if (inOne || inTwo || inThree || inFour) begin // [R7] [R14]
               s_d.divisor = divNext; // [R8]
               s_d.softResetN = 1'b0; // [R13]
               if (inOne) begin
                  s_d.lastClass = CL_ONE;
               end else if (inTwo) begin
                  s_d.lastClass = CL_TWO;
               end else if (inThree) begin
                  s_d.lastClass = CL_THREE;
               end else begin
                  s_d.lastClass = CL_FOUR;
               end
            end else begin
               s_d.lastClass = CL_REJECT;
            end
            s_d.fsm = ST_RELEASE;
         end
         ST_RELEASE: begin
            s_d.softResetN = 1'b1; // [R13]
            s_d.fsm = ST_FIRST; // [R11]
         end
         default: s_d.fsm = ST_FIRST;
      endcase
      // one wait cycle per access; the edge with waitrequest low completes it
      s_d.waitReq = !busTake;
      // writes leave the last read word standing for the master
      if (busTake) begin
         if (avs_read) begin
            s_d.readData = 32'h00000000;
            if (avs_address == `UABM_OFS_CAPTURE_CTRL) begin
               s_d.readData[3:0] = s_q.ctrl;
            end else if (avs_address == `UABM_OFS_WIDTH) begin
               s_d.readData[23:0] = s_q.width;
            end else if (avs_address == `UABM_OFS_DIVISOR) begin
               s_d.readData[15:0] = s_q.divisor;
            end else if (avs_address == `UABM_OFS_STATUS) begin
               s_d.readData[4:0] = {s_q.lastClass, s_q.fsm};
            end
         end
      end
      if (avs_write && !s_q.waitReq && avs_byteenable[0]) begin
         if (avs_address == `UABM_OFS_CAPTURE_CTRL) begin
            s_d.ctrl.edgeSel = avs_writedata[`UABM_CTRL_EDGE_MSB:`UABM_CTRL_EDGE_LSB];
            s_d.ctrl.srcSel = avs_writedata[`UABM_CTRL_SRC_BIT];
            s_d.ctrl.enable = avs_writedata[`UABM_CTRL_EN_BIT];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s_q.fsm <= ST_FIRST;
         s_q.ctrl.enable <= `UABM_RST_EN;
         s_q.ctrl.srcSel <= `UABM_RST_SRC; // [R9]
         s_q.ctrl.edgeSel <= `UABM_RST_EDGE; // [R10]
         s_q.lastClass <= CL_NONE;
         s_q.count <= 24'h000000;
         s_q.stamp <= 24'h000000;
         s_q.width <= 24'h000000;
         s_q.divisor <= `UABM_RST_DIV;
         s_q.softResetN <= 1'b1;
         s_q.inPrev <= 1'b1;
         s_q.waitReq <= 1'b1;
         s_q.readData <= 32'h00000000;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_readdata = s_q.readData;
   assign avs_waitrequest = s_q.waitReq;

   // both ports carry the same divisor and reset, straight from the state flops
   for (genvar p = 0; p < 2; p++) begin : g_port
      assign portCfg[p].midDiv = s_q.divisor[15:`UABM_MID_SHIFT]; // [R8]
      assign portCfg[p].lowDiv = 8'(s_q.divisor & `UABM_LOW_MASK); // [R8]
      assign portCfg[p].softResetN = s_q.softResetN;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_one_bit_load: assert property (s_q.fsm == ST_APPLY && inOne |=> // [R12]
      s_q.divisor == {3'h0, $past(s_q.width[15:3])} - 16'h0001)
      else $error("one-bit divisor wrong");
   a_two_bit_load: assert property (s_q.fsm == ST_APPLY && inTwo |=> // [R2]
      s_q.divisor == $past(s_q.width[19:4]) - 16'h0001 && !s_q.softResetN)
      else $error("two-bit divisor wrong");
   a_three_bit_load: assert property (s_q.fsm == ST_APPLY && inThree |=> // [R4]
      s_q.divisor == 16'(($past(s_q.width) * 2730) >> 16) - 16'h0001)
      else $error("three-bit divisor wrong");
   a_four_bit_load: assert property (s_q.fsm == ST_APPLY && inFour |=> // [R6]
      s_q.divisor == $past(s_q.width[20:5]) - 16'h0001)
      else $error("four-bit divisor wrong");
   a_range_reject: assert property (s_q.fsm == ST_APPLY && !(inOne || inTwo || inThree || inFour) // [R14]
      |=> ($stable(s_q.divisor) && s_q.softResetN) [*2])
      else $error("out-of-range width changed ports");
   a_long_reject: assert property (s_q.fsm == ST_APPLY && s_q.width > `UABM_FOUR_MAX // [R7]
      |=> s_q.lastClass == CL_REJECT && $stable(s_q.divisor))
      else $error("long pulse adjusted divisor");
   a_port_split: assert property ($changed(s_q.divisor) |-> // [R8]
      portCfg[1].midDiv == s_q.divisor[15:8] && portCfg[0].lowDiv == s_q.divisor[7:0]
      && portCfg[0] == portCfg[1])
      else $error("port fields not split or not equal");
   a_reset_pulse: assert property ($fell(portCfg[0].softResetN) |-> // [R13]
      $past(s_q.fsm) == ST_APPLY ##1 portCfg[0].softResetN && portCfg[1].softResetN)
      else $error("soft reset not a one-cycle low pulse");
   a_fall_stamp: assert property (s_q.fsm == ST_FIRST && s_q.ctrl == 4'b1010 // [R10]
      && s_q.inPrev && !captureInputPin |=> s_q.fsm == ST_SECOND && s_q.stamp == $past(s_q.count))
      else $error("falling edge on pin not stamped");
   a_no_rise_stamp: assert property (s_q.fsm == ST_FIRST && s_q.ctrl == 4'b1010 // [R9]
      && !(s_q.inPrev && !captureInputPin) |=> s_q.fsm == ST_FIRST)
      else $error("stamp taken without falling pin edge");
   a_width_diff: assert property (s_q.fsm == ST_APPLY && $past(s_q.fsm) == ST_SECOND |-> // [R11]
      s_q.width == $past(s_q.count) - $past(s_q.stamp) ##2 s_q.fsm == ST_FIRST)
      else $error("width not stamp difference or no rearm");
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");

   // bus side: ctrl writes land, everything else leaves ctrl alone
   a_ctrl_write: assert property (avs_write && !avs_waitrequest && avs_byteenable[0] // [R9]
      && avs_address == `UABM_OFS_CAPTURE_CTRL
      |=> s_q.ctrl == $past(avs_writedata[3:0]))
      else $error("ctrl write not taken");

   a_ctrl_hold: assert property (!(avs_write && !avs_waitrequest)
      |=> $stable(s_q.ctrl))
      else $error("ctrl changed without write");

   a_unmapped_read: assert property (avs_read && avs_waitrequest && avs_address != `UABM_OFS_CAPTURE_CTRL
      && avs_address != `UABM_OFS_WIDTH && avs_address != `UABM_OFS_DIVISOR && avs_address != `UABM_OFS_STATUS
      |=> avs_readdata == 32'h00000000)
      else $error("unmapped read not zero");

   a_wait_idle: assert property (!avs_read && !avs_write
      |=> avs_waitrequest)
      else $error("waitrequest low without request");

   a_wait_one: assert property (!avs_waitrequest
      |=> avs_waitrequest)
      else $error("waitrequest low too long");

   a_read_hold: assert property (!(avs_read && avs_waitrequest)
      |=> $stable(avs_readdata))
      else $error("read data changed without read");

   a_div_read: assert property (avs_read && avs_waitrequest && avs_address == `UABM_OFS_DIVISOR
      |=> avs_readdata == {16'h0000, $past(s_q.divisor)})
      else $error("divisor read wrong");

   a_width_read: assert property (avs_read && avs_waitrequest && avs_address == `UABM_OFS_WIDTH
      |=> avs_readdata == {8'h00, $past(s_q.width)})
      else $error("width read wrong");

   a_status_read: assert property (avs_read && avs_waitrequest && avs_address == `UABM_OFS_STATUS
      |=> avs_readdata[4:0] == $past({s_q.lastClass, s_q.fsm}))
      else $error("status read wrong");

   // port side: only the apply step may change divisor or pull soft reset low
   a_div_source: assert property ($changed(s_q.divisor) // [R14]
      |-> $past(s_q.fsm) == ST_APPLY)
      else $error("divisor changed outside apply");

   a_soft_source: assert property (!portCfg[0].softResetN // [R13]
      |-> $past(s_q.fsm) == ST_APPLY)
      else $error("soft reset low outside apply");

   a_ports_equal: assert property (portCfg[0] == portCfg[1] // [R8]
      )
      else $error("ports differ");

   a_apply_once: assert property (s_q.fsm == ST_APPLY
      |=> s_q.fsm == ST_RELEASE)
      else $error("apply not followed by release");

   a_release_next: assert property (s_q.fsm == ST_RELEASE // [R13]
      |=> s_q.fsm == ST_FIRST && s_q.softResetN)
      else $error("release did not rearm");

   a_stamp_second: assert property (s_q.fsm == ST_SECOND && s_q.ctrl.enable && edgeSeen // [R11]
      |=> s_q.fsm == ST_APPLY)
      else $error("second edge not taken");

   a_class_short: assert property (s_q.fsm == ST_APPLY && s_q.width < `UABM_ONE_MIN // [R14]
      |=> s_q.lastClass == CL_REJECT)
      else $error("short pulse not rejected");

   a_one_class: assert property (s_q.fsm == ST_APPLY && inOne // [R12]
      |=> s_q.lastClass == CL_ONE)
      else $error("one-bit class wrong");

   a_two_class: assert property (s_q.fsm == ST_APPLY && inTwo // [R1]
      |=> s_q.lastClass == CL_TWO)
      else $error("two-bit class wrong");

   a_three_class: assert property (s_q.fsm == ST_APPLY && inThree // [R3]
      |=> s_q.lastClass == CL_THREE)
      else $error("three-bit class wrong");

   a_four_class: assert property (s_q.fsm == ST_APPLY && inFour // [R5]
      |=> s_q.lastClass == CL_FOUR)
      else $error("four-bit class wrong");

   c_one_bit: cover property (s_q.fsm == ST_APPLY && inOne);
   c_two_bit: cover property (s_q.fsm == ST_APPLY && inTwo);
   c_three_bit: cover property (s_q.fsm == ST_APPLY && inThree);
   c_reject: cover property (s_q.fsm == ST_APPLY && s_q.width > `UABM_FOUR_MAX);
   c_ctrl_write: cover property (avs_write && !avs_waitrequest);

endmodule : uabm_matcher

//--- tb/uabm_peer.sv
// peer transmitter model: sends start-bit falls spaced a given number of counts
`timescale 1ns/1ps
module uabm_peer (
   // clock
   input wire logic clock,
   // request
   input wire logic go,
   input wire logic [23:0] width,
   // serial line
   output logic pin,
   output logic busy
);
   int cnt = 0;
   initial pin = 1'b1;
   initial busy = 1'b0;
   always @(posedge clock) begin
      if (go && !busy) begin
         busy <= 1'b1;
         cnt <= 0;
         pin <= 1'b0; // start bit falls
      end else if (busy) begin
         cnt <= cnt + 1;
         // short low pulses: only start-bit edges are timed, so data bits can be idle-high
         if (cnt == 3 || cnt == width + 3) pin <= 1'b1;
         if (cnt == width - 1) pin <= 1'b0; // next frame start bit
         if (cnt == width + 3) busy <= 1'b0;
      end
   end
endmodule : uabm_peer

//--- tb/uabm_matcher_tb.sv
// self-checking bench for the auto baud matcher
`timescale 1ns/1ps
module uabm_matcher_tb import uabm_pkg::*; ;
   typedef struct packed {logic [23:0] w; logic [2:0] c;} uabm_tbrow_type;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic peerGo = 1'b0;
   logic [23:0] peerWidth = 24'h0;
   logic pinLine;
   logic peerBusy;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   uabm_port_cfg_type portCfg [2];
   int nErrors = 0;
   int samplesChecked = 0;
   logic [15:0] divExp = 16'h0;
   logic [31:0] rd;
   // boundary widths of every class plus the widths just below one-bit and just above two-bit and four-bit
   uabm_tbrow_type rows [11] = '{'{24'hb85, 3'h7}, '{24'hb86, 3'h1}, '{24'he24, 3'h1},
      '{24'h170c, 3'h2}, '{24'h1c49, 3'h7}, '{24'h1c48, 3'h2}, '{24'h2292, 3'h3},
      '{24'h2a6c, 3'h3}, '{24'h2e19, 3'h4}, '{24'h3892, 3'h7}, '{24'h3891, 3'h4}};
   always #25 clock = ~clock;
   uabm_matcher u_dut (.clock(clock), .srst(srst), .captureInputPin(pinLine), .rxLineInternal(1'b1),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .portCfg(portCfg));
   uabm_peer u_peer (.clock(clock), .go(peerGo), .width(peerWidth), .pin(pinLine), .busy(peerBusy));
   task automatic endSim();
      if (nErrors == 0 && samplesChecked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : endSim
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      samplesChecked++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", what, e, g);
         nErrors++;
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         chk("bus answer", 32'h0, 32'h1);
         endSim();
      end
   endtask : bus
   // one measured pulse; c is the class the width should get, sc the status class expected
   task automatic meas(input logic [23:0] w, input logic [2:0] c, input logic [2:0] sc);
      int lows;
      logic [15:0] e;
      e = divExp;
      case (c)
         3'h1: e = 16'(w >> 3) - 16'h1;
         3'h2: e = 16'((w >> 4) & 24'hffff) - 16'h1;
         3'h3: e = 16'((32'(w) * 32'haaa) >> 16) - 16'h1;
         3'h4: e = 16'(w >> 5) - 16'h1;
         default: e = divExp;
      endcase
      lows = 0;
      @(posedge clock);
      peerWidth <= w;
      peerGo <= 1'b1;
      @(posedge clock);
      peerGo <= 1'b0;
      for (int k = 0; k < w + 12; k++) begin
         @(posedge clock);
         if (portCfg[0].softResetN === 1'b0) lows++;
      end
      chk("soft reset cycles", (c == 3'h7) ? 32'h0 : 32'h1, 32'(lows));
      for (int p = 0; p < 2; p++) begin
         chk("mid divisor", 32'(e[15:8]), 32'(portCfg[p].midDiv));
         chk("low divisor", 32'(e[7:0]), 32'(portCfg[p].lowDiv));
         chk("soft reset idle", 32'h1, 32'(portCfg[p].softResetN));
      end
      bus(1'b0, 4'hc, 32'h0, rd);
      chk("class", 32'(sc), 32'(rd[4:2]));
      chk("rearmed", 32'h0, 32'(rd[1:0]));
      bus(1'b0, 4'h8, 32'h0, rd);
      chk("divisor reg", 32'(e), rd);
      divExp = e;
   endtask : meas
   initial begin
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      bus(1'b0, 4'h0, 32'h0, rd);
      chk("ctrl reset", 32'ha, rd);
      bus(1'b0, 4'h1, 32'h0, rd);
      chk("unmapped read", 32'h0, rd);
      bus(1'b0, 4'h8, 32'h0, rd);
      chk("divisor reset", 32'h0, rd);
      foreach (rows[i]) meas(rows[i].w, rows[i].c, rows[i].c);
      bus(1'b1, 4'h8, 32'hffff, rd);
      // internal source selected: pin pulses must be ignored
      bus(1'b1, 4'h0, 32'he, rd);
      bus(1'b0, 4'h0, 32'h0, rd);
      chk("ctrl write", 32'he, rd);
      meas(24'h000100, 3'h7, 3'h4);
      bus(1'b1, 4'h0, 32'ha, rd);
      meas(24'hb86, 3'h1, 3'h1);
      // rising-edge timing, then both edges, then capture edge off
      bus(1'b1, 4'h0, 32'h9, rd);
      meas(24'he24, 3'h1, 3'h1);
      bus(1'b1, 4'h0, 32'hb, rd);
      meas(24'h000100, 3'h7, 3'h7);
      bus(1'b1, 4'h0, 32'h8, rd);
      meas(24'h000100, 3'h7, 3'h7);
      bus(1'b1, 4'h0, 32'ha, rd);
      // reset in mid-run
      @(posedge clock);
      srst <= 1'b1;
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      chk("mid after reset", 32'h0, 32'(portCfg[1].midDiv));
      chk("low after reset", 32'h0, 32'(portCfg[1].lowDiv));
      bus(1'b0, 4'h0, 32'h0, rd);
      chk("ctrl after reset", 32'ha, rd);
      endSim();
   end
endmodule : uabm_matcher_tb
